// *** hdl/filter_regs.svh ***
// register offsets, field positions, reset values and timing counts of the half-band filter
`ifndef FILTER_REGS_SVH
`define FILTER_REGS_SVH

`define APB_ADDR_W 8
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define LAST_OUT_OFFSET 8'h08

`define CTRL_W 7
`define CTRL_RESET 7'h07
`define CTRL_PSTRB_LANE 0

`define TAP_COUNT 55
`define CENTER_TAP 27
`define COEF_PAIRS 14
`define CENTER_COEF_SHIFT 15

`define OUT_SHIFT_HALF 6'h0c
`define OUT_SHIFT_UNITY 6'h0b
`define SAT_MAX16 16'h7fff
`define SAT_MIN16 16'h8000
`define SAT_MAX15 16'h3fff
`define SAT_MIN15 16'hc000
`define INV_OFFSET_MASK 16'h7fff
`define LOW_MASK_ALL 16'hffff

`define CLK_PERIOD_NS 4
`define LATENCY_FIRST_CYC 7
`define LATENCY_PEAK_CYC 34
`define LATENCY_LAST_CYC 61

`endif

// *** hdl/filter_pkg.sv ***
// types shared by the half-band filter modules
package filter_pkg;

  typedef struct packed {
    logic variant_unity;
    logic [2:0] round_width_select;
    logic output_format_select;
    logic interpolate_select_n;
    logic decimate_select_n;
  } ctrl_t;

  typedef enum logic [3:0] {
    MODE_EQUAL = 4'b0001,
    MODE_DECIM = 4'b0010,
    MODE_INTERP_HALF = 4'b0100,
    MODE_INTERP_UNITY = 4'b1000
  } mode_t;

  typedef struct packed {
    logic unity_shift;
    logic clamp15;
    logic twos_complement;
    logic [2:0] round_sel;
  } lim_cfg_t;

endpackage : filter_pkg

// *** hdl/sample_shift_line.sv ***
// delay line holding the most recent filter input samples, one word per tap
`timescale 1ns/1ps
module sample_shift_line
  import filter_pkg::*;
#(
  parameter int W = 12,
  parameter int DEPTH = 55
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] din_i,
  output logic [DEPTH*W-1:0] taps_o
);

  logic [W-1:0] line_ff [DEPTH];
  logic [W-1:0] nxt_line [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_stage
      if (g == 0)
      begin : g_head
        always_comb nxt_line[g] = din_i;
      end
      else
      begin : g_body
        always_comb nxt_line[g] = line_ff[g-1];
      end
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          line_ff[g] <= '0;
        else
          line_ff[g] <= nxt_line[g];
      end
      assign taps_o[g*W +: W] = line_ff[g];
    end
  endgenerate

endmodule : sample_shift_line

// *** hdl/output_limiter.sv ***
// rounding, saturation, low-bit zeroing and output formatting stage
`timescale 1ns/1ps
`include "filter_regs.svh"
module output_limiter
  import filter_pkg::*;
#(
  parameter int ACC_W = 36
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic signed [ACC_W-1:0] acc_i,
  input wire lim_cfg_t cfg_i,
  output logic [15:0] result_o,
  output logic sat_o
);

  logic [15:0] result_ff;
  logic sat_ff;
  logic [15:0] nxt_result;
  logic nxt_sat;

  always_comb
  begin
    logic [5:0] shift;
    logic [5:0] half_pos;
    logic signed [ACC_W-1:0] rounded;
    logic signed [ACC_W-1:0] scaled;
    logic signed [ACC_W-1:0] max_v;
    logic signed [ACC_W-1:0] min_v;
    logic [15:0] clipped;
    logic [15:0] low_mask;
    clipped = 16'h0;
    shift = cfg_i.unity_shift ? `OUT_SHIFT_UNITY : `OUT_SHIFT_HALF;
    // half an lsb at the chosen width, then drop the fraction
    half_pos = shift + {3'h0, cfg_i.round_sel} - 6'h01;
    rounded = acc_i + (ACC_W'(1) << half_pos);
    scaled = rounded >>> shift;
    max_v = cfg_i.clamp15 ? ACC_W'(signed'(`SAT_MAX15)) : ACC_W'(signed'(`SAT_MAX16));
    min_v = cfg_i.clamp15 ? ACC_W'(signed'(`SAT_MIN15)) : ACC_W'(signed'(`SAT_MIN16));
    nxt_sat = 1'b0;
    if (scaled > max_v)
    begin
      clipped = max_v[15:0];
      nxt_sat = 1'b1;
    end
    else if (scaled < min_v)
    begin
      clipped = min_v[15:0];
      nxt_sat = 1'b1;
    end
    else
      clipped = scaled[15:0];
    low_mask = `LOW_MASK_ALL << cfg_i.round_sel;
    // mask after the format flip so the dropped bits read zero in both formats
    nxt_result = (cfg_i.twos_complement ? clipped : clipped ^ `INV_OFFSET_MASK) & low_mask;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      result_ff <= '0;
      sat_ff <= 1'b0;
    end
    else
    begin
      result_ff <= nxt_result;
      sat_ff <= nxt_sat;
    end
  end

  assign result_o = result_ff;
  assign sat_o = sat_ff;

endmodule : output_limiter

// *** hdl/halfband_rate_change_filter.sv ***
// half-band rate change filter top: input alignment, fir datapath, output register, apb slave
//
// How it works
// - symmetric 55-tap linear-phase low-pass fir
// - impulse to output peak takes 34 cycles
// - response spans cycles 7 to 61
// - interpolation: half-rate input, zeros inserted between
// - decimation: one output per two inputs
// - aligned interpolation captures every second edge
// - format select: twos complement or inverted offset
// - half-lsb rounding at selected width 9..16
// - output enable floats port asynchronously
// - decimate select low: full-rate in, half-rate out
// - interpolate select low: half-rate in, -6 dB
// - both high equal rate; both low per variant
// - equal rate: one in, one out per cycle
// - 15-bit limit in variant -6 dB interpolation
// - saturate on overflow, never wrap
// - 12-bit twos complement in, 16-bit out
// - limits 7fff/8000, or 3fff/c000 there
// - bits below rounding position read zero
// - strobe ignored in equal-rate mode
// - registers on rising edge; decimated output held
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "filter_regs.svh"
module halfband_rate_change_filter
  import filter_pkg::*;
#(
  parameter int IN_W = 12,
  parameter int OUT_W = 16,
  parameter int COEF_W = 18,
  parameter int ACC_W = 36
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [IN_W-1:0] sample_in_i,
  input wire logic align_strobe_i,
  input wire logic output_enable_n_i,
  output logic [OUT_W-1:0] sample_out_o,
  output logic sample_out_oe_o,
  output logic sample_out_strobe_o,
  input wire logic [`APB_ADDR_W-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  localparam int NPAIR = `COEF_PAIRS;
  localparam int NTAP = `TAP_COUNT;
  localparam int CTR = `CENTER_TAP;

  // half-band: only the centre and odd offsets from centre carry weight, scale 2^16
  localparam logic signed [COEF_W-1:0] COEF [NPAIR] = '{
    18'sd20795, -18'sd6757, 18'sd3853, -18'sd2549, 18'sd1776, -18'sd1258, 18'sd891,
    -18'sd616, 18'sd406, -18'sd256, 18'sd144, -18'sd69, 18'sd23, -18'sd2
  };

  // pin synchronisers; sample and strobe share depth so they stay aligned
  logic [IN_W-1:0] din_meta_ff;
  logic [IN_W-1:0] din_sync_ff;
  logic strobe_meta_ff;
  logic strobe_sync_ff;
  logic strobe_prev_ff;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      din_meta_ff <= '0;
      din_sync_ff <= '0;
      strobe_meta_ff <= 1'b0;
      strobe_sync_ff <= 1'b0;
      strobe_prev_ff <= 1'b0;
    end
    else
    begin
      din_meta_ff <= sample_in_i;
      din_sync_ff <= din_meta_ff;
      strobe_meta_ff <= align_strobe_i;
      strobe_sync_ff <= strobe_meta_ff;
      strobe_prev_ff <= strobe_sync_ff;
    end
  end

  // control register and mode decode
  ctrl_t ctrl_ff;
  ctrl_t nxt_ctrl;
  mode_t mode;
  lim_cfg_t lim_cfg;

  always_comb
  begin
    unique case ({ctrl_ff.decimate_select_n, ctrl_ff.interpolate_select_n})
      2'b01: mode = MODE_DECIM;
      2'b10: mode = MODE_INTERP_HALF;
      2'b11: mode = MODE_EQUAL;
      2'b00: mode = ctrl_ff.variant_unity ? MODE_INTERP_UNITY : MODE_EQUAL;
    endcase
    lim_cfg.unity_shift = (mode == MODE_INTERP_UNITY);
    lim_cfg.clamp15 = ctrl_ff.variant_unity && (mode == MODE_INTERP_HALF);
    lim_cfg.twos_complement = ctrl_ff.output_format_select;
    lim_cfg.round_sel = ctrl_ff.round_width_select;
  end

  // input and output phase tracking
  logic in_phase_ff;
  logic out_phase_ff;
  logic aligned_ff;
  logic nxt_in_phase;
  logic nxt_out_phase;
  logic nxt_aligned;
  logic strobe_fall;
  logic in_take;
  logic out_take;
  logic interp_mode;

  always_comb
  begin
    interp_mode = (mode == MODE_INTERP_HALF) || (mode == MODE_INTERP_UNITY);
    // a falling strobe marks the first wanted sample; a toggling strobe
    // falls only on capture edges once aligned, so nothing changes
    strobe_fall = strobe_prev_ff && !strobe_sync_ff && (mode != MODE_EQUAL);
    in_take = 1'b1;
    out_take = 1'b1;
    if (interp_mode)
      in_take = strobe_fall || in_phase_ff;
    if (mode == MODE_DECIM)
      out_take = strobe_fall || out_phase_ff;
    nxt_in_phase = !in_take;
    nxt_out_phase = !out_take;
    nxt_aligned = aligned_ff;
    if (mode == MODE_EQUAL)
      nxt_aligned = 1'b0;
    else if (strobe_fall)
      nxt_aligned = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      in_phase_ff <= 1'b0;
      out_phase_ff <= 1'b0;
      aligned_ff <= 1'b0;
    end
    else
    begin
      in_phase_ff <= nxt_in_phase;
      out_phase_ff <= nxt_out_phase;
      aligned_ff <= nxt_aligned;
    end
  end

  // zero stuffing between captured samples in interpolation
  logic [IN_W-1:0] line_din;
  logic [NTAP*IN_W-1:0] taps;

  always_comb
  begin
    line_din = in_take ? din_sync_ff : '0;
  end

  sample_shift_line #(
    .W(IN_W),
    .DEPTH(NTAP)
  ) u_line (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .din_i(line_din),
    .taps_o(taps)
  );

  // stage a: fold symmetric taps into pair sums
  logic signed [IN_W:0] pair_ff [NPAIR];
  logic signed [IN_W:0] nxt_pair [NPAIR];
  logic signed [IN_W-1:0] centre_ff;
  logic signed [IN_W-1:0] nxt_centre;

  genvar j;
  generate
    for (j = 0; j < NPAIR; j++)
    begin : g_pair
      localparam int KLO = CTR - (2 * j + 1);
      localparam int KHI = CTR + (2 * j + 1);
      always_comb
      begin
        nxt_pair[j] = (IN_W+1)'(signed'(taps[KLO*IN_W +: IN_W]))
          + (IN_W+1)'(signed'(taps[KHI*IN_W +: IN_W]));
      end
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          pair_ff[j] <= '0;
        else
          pair_ff[j] <= nxt_pair[j];
      end
    end
  endgenerate

  always_comb nxt_centre = signed'(taps[CTR*IN_W +: IN_W]);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      centre_ff <= '0;
    else
      centre_ff <= nxt_centre;
  end

  // stage b: multiply-accumulate; centre weight is one half
  logic signed [ACC_W-1:0] acc_ff;
  logic signed [ACC_W-1:0] nxt_acc;

  always_comb
  begin
    nxt_acc = ACC_W'(centre_ff) <<< `CENTER_COEF_SHIFT;
    for (int k = 0; k < NPAIR; k++)
      nxt_acc = nxt_acc + ACC_W'(pair_ff[k] * COEF[k]);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      acc_ff <= '0;
    else
      acc_ff <= nxt_acc;
  end

  // stage c: round, limit, format
  logic [OUT_W-1:0] lim_result;
  logic lim_sat;

  output_limiter #(
    .ACC_W(ACC_W)
  ) u_limiter (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .acc_i(acc_ff),
    .cfg_i(lim_cfg),
    .result_o(lim_result),
    .sat_o(lim_sat)
  );

  // output register, held on odd phases while decimating
  logic [OUT_W-1:0] out_ff;
  logic out_strobe_ff;
  logic sat_seen_ff;
  logic [OUT_W-1:0] nxt_out;
  logic nxt_out_strobe;
  logic nxt_sat_seen;
  logic status_rd;

  always_comb
  begin
    nxt_out = out_take ? lim_result : out_ff;
    nxt_out_strobe = out_take;
    nxt_sat_seen = sat_seen_ff;
    if (status_rd)
      nxt_sat_seen = 1'b0;
    // an overflow in the read cycle is kept for the next read
    if (out_take && lim_sat)
      nxt_sat_seen = 1'b1;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      out_ff <= '0;
      out_strobe_ff <= 1'b0;
      sat_seen_ff <= 1'b0;
    end
    else
    begin
      out_ff <= nxt_out;
      out_strobe_ff <= nxt_out_strobe;
      sat_seen_ff <= nxt_sat_seen;
    end
  end

  assign sample_out_o = out_ff;
  // enable bypasses the clock so a shared bus is released at once
  assign sample_out_oe_o = !output_enable_n_i;

  assign sample_out_strobe_o = out_strobe_ff;

  // apb slave: zero wait states, answer registered in the setup cycle
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  logic nxt_pready;
  logic nxt_pslverr;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] status_word;

  always_comb
  begin
    setup = psel_i && !penable_i;
    access = psel_i && penable_i && pready_ff;
    mapped = (paddr_i == `CTRL_OFFSET) || (paddr_i == `STATUS_OFFSET)
      || (paddr_i == `LAST_OUT_OFFSET);
    status_word = {24'h0, sat_seen_ff, aligned_ff, out_phase_ff, in_phase_ff, mode};
    status_rd = access && !pwrite_i && (paddr_i == `STATUS_OFFSET);
    nxt_prdata = prdata_ff;
    nxt_pready = setup;
    nxt_pslverr = setup && !mapped;
    if (setup && !pwrite_i)
    begin
      unique case (paddr_i)
        `CTRL_OFFSET: nxt_prdata = {25'h0, ctrl_ff};
        `STATUS_OFFSET: nxt_prdata = status_word;
        `LAST_OUT_OFFSET: nxt_prdata = {16'h0, out_ff};
        default: nxt_prdata = 32'h0;
      endcase
    end
    nxt_ctrl = ctrl_ff;
    if (access && pwrite_i && (paddr_i == `CTRL_OFFSET) && pstrb_i[`CTRL_PSTRB_LANE])
      nxt_ctrl = ctrl_t'(pwdata_i[`CTRL_W-1:0]);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_ff <= ctrl_t'(`CTRL_RESET);
      prdata_ff <= '0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;

endmodule : halfband_rate_change_filter

// *** testbench/filter_chk.sv ***
// concurrent checks on the half-band filter top ports
`timescale 1ns/1ps
`include "filter_regs.svh"
module filter_chk
  import filter_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic output_enable_n_i,
  input wire logic [15:0] sample_out_o,
  input wire logic sample_out_oe_o,
  input wire logic sample_out_strobe_o,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o
);
  ctrl_t ctrl_ff, nxt_ctrl;
  logic [3:0] st_ff, nxt_st;
  logic wr, calm, eq, dec, itp, c15;
  assign wr = psel_i & penable_i & pready_o & pwrite_i & (paddr_i == `CTRL_OFFSET) & pstrb_i[0];
  // calm: no control write for 15 cycles, pipeline has settled
  assign calm = st_ff == 4'hf;
  assign eq = (ctrl_ff.decimate_select_n == ctrl_ff.interpolate_select_n) & ~itp;
  assign dec = ~ctrl_ff.decimate_select_n & ctrl_ff.interpolate_select_n;
  assign c15 = ctrl_ff.decimate_select_n & ~ctrl_ff.interpolate_select_n & ctrl_ff.variant_unity;
  assign itp = (ctrl_ff.decimate_select_n & ~ctrl_ff.interpolate_select_n)
    | (ctrl_ff.variant_unity & ~ctrl_ff.decimate_select_n & ~ctrl_ff.interpolate_select_n);
  always_comb
  begin
    nxt_ctrl = wr ? ctrl_t'(pwdata_i[6:0]) : ctrl_ff;
    nxt_st = wr ? 4'h0 : (calm ? st_ff : st_ff + 4'h1);
  end
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_ff <= ctrl_t'(`CTRL_RESET);
      st_ff <= 4'h0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      st_ff <= nxt_st;
    end
  end
  property p_oe;
    @(posedge clk_i) disable iff (!rstn_i) sample_out_oe_o == !output_enable_n_i;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable mismatch");
  property p_eq;
    @(posedge clk_i) disable iff (!rstn_i) calm && eq |-> sample_out_strobe_o;
  endproperty
  a_eq: assert property (p_eq) else $error("equal rate output missing");
  property p_itp;
    @(posedge clk_i) disable iff (!rstn_i) calm && itp |-> sample_out_strobe_o;
  endproperty
  a_itp: assert property (p_itp) else $error("interpolated output missing");
  property p_alt;
    @(posedge clk_i) disable iff (!rstn_i)
      calm && dec && $past(calm) |-> sample_out_strobe_o != $past(sample_out_strobe_o);
  endproperty
  a_alt: assert property (p_alt) else $error("decimated output not every second cycle");
  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      calm && dec && !sample_out_strobe_o |-> $stable(sample_out_o);
  endproperty
  a_hold: assert property (p_hold) else $error("decimated output changed in hold");
  property p_low;
    @(posedge clk_i) disable iff (!rstn_i)
      calm |-> (sample_out_o & ((16'h1 << ctrl_ff.round_width_select) - 16'h1)) == 16'h0;
  endproperty
  a_low: assert property (p_low) else $error("bits below rounding point set");
  property p_c15;
    @(posedge clk_i) disable iff (!rstn_i) calm && c15 && ctrl_ff.output_format_select
      |-> $signed(sample_out_o) <= $signed(`SAT_MAX15)
      && $signed(sample_out_o) >= $signed(`SAT_MIN15);
  endproperty
  a_c15: assert property (p_c15) else $error("output beyond 15-bit limit");
  property p_ready;
    @(posedge clk_i) disable iff (!rstn_i) psel_i && !penable_i |=> pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("bus access not answered");
endmodule : filter_chk

bind halfband_rate_change_filter filter_chk filter_chk_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .output_enable_n_i(output_enable_n_i),
  .sample_out_o(sample_out_o), .sample_out_oe_o(sample_out_oe_o),
  .sample_out_strobe_o(sample_out_strobe_o), .paddr_i(paddr_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .pready_o(pready_o));

// *** testbench/sample_port_model.sv ***
// sample source and output bus sink facing the filter
`timescale 1ns/1ps
module sample_port_model
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [11:0] word_i,
  input wire logic sync_i,
  input wire logic tog_i,
  input wire logic [15:0] dout_i,
  input wire logic oe_i,
  output logic [11:0] sample_o,
  output logic strobe_o,
  output logic [15:0] bus_o
);
  logic ph_ff, nxt_ph;
  logic [15:0] last_ff, nxt_last;
  assign sample_o = word_i;
  // strobe falls with the first wanted sample, toggling keeps that parity
  assign strobe_o = sync_i | (tog_i & ph_ff);
  // released bus shows the inverse, never a stale value
  assign bus_o = oe_i ? dout_i : ~last_ff;
  always_comb
  begin
    nxt_ph = sync_i ? 1'b0 : ~ph_ff;
    nxt_last = oe_i ? dout_i : last_ff;
  end
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ph_ff <= 1'b0;
      last_ff <= 16'h0;
    end
    else
    begin
      ph_ff <= nxt_ph;
      last_ff <= nxt_last;
    end
  end
endmodule : sample_port_model

// *** testbench/testbench.sv ***
// self-checking bench of the half-band rate change filter
`timescale 1ns/1ps
`include "filter_regs.svh"
module testbench;
  // large enough that the outermost taps survive rounding at 16 bits
  localparam logic [11:0] X = 12'h7c0;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [11:0] word = 12'h0;
  logic sync = 1'b0;
  logic tog = 1'b0;
  logic oe_n = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [11:0] sample_in;
  logic strobe, oe, ostb, pready, perr, e;
  logic [15:0] sample_out, bus;
  logic [31:0] prdata, d;
  logic [15:0] r [72];
  logic [15:0] re [72];
  logic [6:0] mc [5] = '{7'h07, 7'h06, 7'h05, 7'h44, 7'h00};
  logic [3:0] ms [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
  int err_count = 0;
  int num_checks = 0;
  always #2 clk_i = ~clk_i;
  halfband_rate_change_filter halfband_rate_change_filter_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .sample_in_i(sample_in), .align_strobe_i(strobe),
    .output_enable_n_i(oe_n), .sample_out_o(sample_out), .sample_out_oe_o(oe),
    .sample_out_strobe_o(ostb), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr));
  sample_port_model sample_port_model_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .word_i(word), .sync_i(sync), .tog_i(tog),
    .dout_i(sample_out), .oe_i(oe), .sample_o(sample_in), .strobe_o(strobe), .bus_o(bus));
  function automatic logic [15:0] pk(input int s);
    return {{4{X[11]}}, X} << s;
  endfunction : pk
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hf;
    @(posedge clk_i);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a hung transfer
    do
    begin
      @(posedge clk_i);
    end
    while (pready !== 1'b1);
    d = prdata;
    e = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask : apb
  task automatic imp(input logic [6:0] c, input logic t, input int h);
    int k;
    apb(1'b1, `CTRL_OFFSET, {25'h0, c});
    tog <= t;
    word <= 12'h0;
    repeat (70) @(posedge clk_i);
    sync <= 1'b1;
    @(posedge clk_i);
    sync <= 1'b0;
    word <= X;
    for (k = 1; k < 72; k++)
    begin
      @(posedge clk_i);
      if (k == h)
        word <= 12'h0;
      #1 r[k] = sample_out;
    end
    @(posedge clk_i);
  endtask : imp
  task automatic same(input logic [15:0] m);
    for (int k = 1; k < 72; k++)
      chk(r[k], re[k] ^ m);
  endtask : same
  // a full-scale square wave overshoots, so both limits must be reached
  task automatic sq(input logic [6:0] c, input logic [15:0] hi, input logic [15:0] lo);
    logic sh, sl;
    sh = 1'b0;
    sl = 1'b0;
    apb(1'b1, `CTRL_OFFSET, {25'h0, c});
    for (int k = 0; k < 400; k++)
    begin
      @(posedge clk_i);
      word <= (k % 80 < 40) ? 12'h7ff : 12'h800;
      #1;
      sh |= sample_out === hi;
      sl |= sample_out === lo;
    end
    chk(sh, 1'b1);
    chk(sl, 1'b1);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    chk(d[7], 1'b1);
  endtask : sq
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial
  begin
    int n;
    n = $urandom(32'hb398);
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    chk(sample_out, 16'h0);
    apb(1'b0, `CTRL_OFFSET, 32'h0);
    chk(d, {25'h0, `CTRL_RESET});
    apb(1'b0, 8'h0c, 32'h0);
    chk(d, 32'h0);
    chk({31'h0, e}, 32'h1);
    foreach (mc[i])
    begin
      apb(1'b1, `CTRL_OFFSET, {25'h0, mc[i]});
      apb(1'b0, `STATUS_OFFSET, 32'h0);
      chk(d[3:0], ms[i]);
    end
    imp(7'h07, 1'b0, 1);
    chk(r[6], 16'h0);
    chk(r[7] != 16'h0, 1'b1);
    chk(r[34], pk(3));
    chk(r[61] != 16'h0, 1'b1);
    chk(r[62], 16'h0);
    for (int k = 0; k < 27; k++)
      chk(r[7 + k], r[61 - k]);
    re = r;
    imp(7'h07, 1'b1, 1);
    same(16'h0);
    imp(7'h05, 1'b0, 2);
    same(16'h0);
    imp(7'h05, 1'b1, 2);
    same(16'h0);
    imp(7'h03, 1'b0, 1);
    same(`INV_OFFSET_MASK);
    imp(7'h44, 1'b0, 2);
    chk(r[34], pk(4));
    imp(7'h3f, 1'b0, 1);
    chk(r[34], pk(3));
    sq(7'h07, `SAT_MAX16, `SAT_MIN16);
    sq(7'h45, `SAT_MAX15, `SAT_MIN15);
    tog <= 1'b0;
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, `CTRL_OFFSET, {26'h0, 3'($urandom), 1'($urandom), 2'b10});
      n = 0;
      for (int k = 0; k < 100; k++)
      begin
        @(posedge clk_i);
        word <= 12'($urandom);
        #1;
        if (k >= 20 && ostb === 1'b1)
          n++;
      end
      chk(n, 40);
    end
    // back to two's complement so an idle output reads zero
    apb(1'b1, `CTRL_OFFSET, {25'h0, `CTRL_RESET});
    word <= 12'h0;
    repeat (80) @(posedge clk_i);
    chk(sample_out, 16'h0);
    oe_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(oe, 1'b0);
    chk(bus, 16'hffff);
    oe_n <= 1'b0;
    print_verdict();
  end
  // whole run is about 2300 cycles; this allows some thirteen times that
  initial
  begin
    #120000;
    err_count++;
    print_verdict();
  end
endmodule : testbench
